//--- design/asdec_pkg.sv
// Package for the register and stack-pointer add decoder: offsets, fields, types.
// Assumes an APB master on pclk and one processor clock domain.
//
// How it works
// - Short three-register add, flags only outside block
// - Two-register form; index 1101 redirects to stack-pointer
// - Two-register form no flags; pc misuse unpredictable
// - Wide register, dest 1111 with S: compare_negative
// - Wide register, first operand 1101 redirects
// - Wide register sets flags exactly when S
// - Second operand shifted, carry flag feeds shifter
// - Wide register: bad 13/15 operands unpredictable
// - Add operands with carry-in zero
// - Dest 15 branches; else write, optional flags
// - Stack byte immediate times four, no flags
// - Stack adjust targets 13, seven-bit immediate
// - Wide stack form expands modified constant
// - Wide stack immediate zero-extended, no flags
// - Stack add, carry-in zero, optional flags
package asdec_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] ASDEC_OFF_INSTR = 8'h00;
  localparam logic [7:0] ASDEC_OFF_CTRL = 8'h04;
  localparam logic [7:0] ASDEC_OFF_OPA = 8'h08;
  localparam logic [7:0] ASDEC_OFF_OPB = 8'h0c;
  localparam logic [7:0] ASDEC_OFF_SP = 8'h10;
  localparam logic [7:0] ASDEC_OFF_FLAGS = 8'h14;
  localparam logic [7:0] ASDEC_OFF_GO = 8'h18;
  localparam logic [7:0] ASDEC_OFF_STATUS = 8'h1c;
  localparam logic [7:0] ASDEC_OFF_RESULT = 8'h20;

  // ==========================================================
  // Control bits and flag positions
  localparam int ASDEC_CTRL_IN_BLOCK = 0;
  localparam int ASDEC_CTRL_LAST_IN_BLOCK = 1;
  localparam int ASDEC_CTRL_COND_PASS = 2;
  localparam int ASDEC_FLAG_V = 0;
  localparam int ASDEC_FLAG_C = 1;
  localparam int ASDEC_FLAG_Z = 2;
  localparam int ASDEC_FLAG_N = 3;

  // ==========================================================
  // Reset values
  localparam logic [31:0] ASDEC_RST_WORD = 32'h0000_0000;
  localparam logic [2:0] ASDEC_RST_CTRL = 3'h4;
  localparam logic [3:0] ASDEC_RST_FLAGS = 4'h0;

  // ==========================================================
  // Special register indices
  localparam logic [3:0] ASDEC_REG_SP = 4'hd;
  localparam logic [3:0] ASDEC_REG_PC = 4'hf;

  // ==========================================================
  // Decode classes
  typedef enum logic [2:0] {
    ASDEC_CLS_NONE = 3'b000,
    ASDEC_CLS_ADD_REG = 3'b001,
    ASDEC_CLS_ADD_SP_IMM = 3'b010,
    ASDEC_CLS_SP_PLUS_REG = 3'b011,
    ASDEC_CLS_COMPARE_NEGATIVE_REG = 3'b100,
    ASDEC_CLS_COMPARE_NEGATIVE_IMM = 3'b101
  } asdec_cls_t;

  typedef enum logic [2:0] {
    ASDEC_SH_LSL = 3'b000,
    ASDEC_SH_LSR = 3'b001,
    ASDEC_SH_ASR = 3'b010,
    ASDEC_SH_ROR = 3'b011,
    ASDEC_SH_RRX = 3'b100
  } asdec_shift_t;

  // Decoded instruction
  typedef struct packed {
    asdec_cls_t cls;
    logic [3:0] rd;
    logic [3:0] first_operand_field;
    logic [3:0] second_operand_field;
    logic setflags;
    asdec_shift_t shift_kind;
    logic [5:0] shift_amt;
    logic [31:0] imm32;
    logic unpred;
  } asdec_dec_t;

  // Write-back towards the core
  typedef struct packed {
    logic reg_wr;
    logic pc_wr;
    logic [3:0] idx;
    logic [31:0] data;
  } asdec_wb_t;

endpackage

//--- design/asdec_top.sv
// Add decoder and executor for register adds and stack-pointer immediate adds.
// Assumes an APB master on pclk; software stands in for fetch and register file.
`timescale 1ns/1ps
`default_nettype none

module asdec_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Write-back towards the core
  output asdec_pkg::asdec_wb_t wb,
  output logic [3:0] app_status_flags
);
  import asdec_pkg::*;

  // ==========================================================
  // State
  logic [31:0] instr_q;
  logic [2:0] ctrl_q;
  logic [31:0] opa_q;
  logic [31:0] opb_q;
  logic [31:0] sp_q;
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  logic [31:0] result_q;
  logic done_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  asdec_wb_t wb_q;
  asdec_wb_t wb_d;
  asdec_dec_t dec;

  // ==========================================================
  // Bus decode
  // Ready only once per transfer
  wire setup = psel & ~penable & ~pready_q;
  wire access = psel & penable & pready_q;
  wire wr_acc = access & pwrite;
  wire hit_instr = paddr == ASDEC_OFF_INSTR;
  wire hit_ctrl = paddr == ASDEC_OFF_CTRL;
  wire hit_opa = paddr == ASDEC_OFF_OPA;
  wire hit_opb = paddr == ASDEC_OFF_OPB;
  wire hit_sp = paddr == ASDEC_OFF_SP;
  wire hit_flags = paddr == ASDEC_OFF_FLAGS;
  wire hit_go = paddr == ASDEC_OFF_GO;
  wire hit_status = paddr == ASDEC_OFF_STATUS;
  wire hit_result = paddr == ASDEC_OFF_RESULT;
  wire mapped = hit_instr | hit_ctrl | hit_opa | hit_opb | hit_sp | hit_flags | hit_go | hit_status | hit_result;
  wire ro_write = pwrite & (hit_status | hit_result);
  wire go = wr_acc & hit_go;

  // ==========================================================
  // Instruction fields
  // First halfword sits in the upper half
  wire [15:0] hw1 = instr_q[31:16];
  wire [15:0] hw2 = instr_q[15:0];
  wire in_block = ctrl_q[ASDEC_CTRL_IN_BLOCK];
  wire last_in_block = ctrl_q[ASDEC_CTRL_LAST_IN_BLOCK];
  wire cond_pass = ctrl_q[ASDEC_CTRL_COND_PASS];

  // Encoding matches, resolved in priority order below
  wire is_r16a = hw1[15:9] == 7'b0001100;
  wire is_r16b = hw1[15:8] == 8'b01000100;
  wire is_r32 = hw1[15:5] == 11'b11101011000;
  wire is_s16a = hw1[15:11] == 5'b10101;
  wire is_s16b = hw1[15:7] == 9'b101100000;
  wire wide_sp_hdr = (hw1[15:11] == 5'b11110) & (hw1[3:0] == ASDEC_REG_SP) & ~hw2[15];
  wire is_s32c = wide_sp_hdr & (hw1[9:5] == 5'b01000);
  wire is_s32w = wide_sp_hdr & (hw1[9:4] == 6'b100000);

  wire [3:0] dest_high_idx = {hw1[7], hw1[2:0]};
  wire [3:0] second_operand_field = hw1[6:3];
  wire flag_bit = hw1[4];
  wire [3:0] wide_first = hw1[3:0];
  wire [3:0] wide_dest = hw2[11:8];
  wire [3:0] wide_second = hw2[3:0];
  wire [2:0] split_imm_mid = hw2[14:12];
  wire [1:0] shift_amount_low = hw2[7:6];
  wire [1:0] shift_type_field = hw2[5:4];
  wire [4:0] shift_imm5 = {split_imm_mid, shift_amount_low};
  wire [7:0] byte_immediate = hw1[7:0];
  wire [6:0] seven_bit_immediate = hw1[6:0];
  wire [11:0] imm12 = {hw1[10], split_imm_mid, hw2[7:0]};

  // ==========================================================
  // Modified-constant expansion
  wire [7:0] ex_b = imm12[7:0];
  wire [31:0] ex_unrot = {24'h00_0000, 1'b1, imm12[6:0]};
  wire [63:0] ex_rot2 = {ex_unrot, ex_unrot} >> imm12[11:7];
  wire [31:0] ex_rot = ex_rot2[31:0];
  wire [31:0] ex_val = (imm12[11:10] != 2'b00) ? ex_rot :
                       (imm12[9:8] == 2'b00) ? {24'h00_0000, ex_b} :
                       (imm12[9:8] == 2'b01) ? {8'h00, ex_b, 8'h00, ex_b} :
                       (imm12[9:8] == 2'b10) ? {ex_b, 8'h00, ex_b, 8'h00} :
                       {ex_b, ex_b, ex_b, ex_b};
  // Zero byte under a repeat pattern is refused
  wire ex_bad = (imm12[11:10] == 2'b00) & (imm12[9:8] != 2'b00) & (ex_b == 8'h00);

  // ==========================================================
  // Decode
  always_comb begin
    dec = '0;
    dec.cls = ASDEC_CLS_NONE;
    dec.shift_kind = ASDEC_SH_LSL;
    if (is_r16a) begin
      // three low registers, flags outside block
      dec.cls = ASDEC_CLS_ADD_REG;
      dec.second_operand_field = {1'b0, hw1[8:6]};
      dec.first_operand_field = {1'b0, hw1[5:3]};
      dec.rd = {1'b0, hw1[2:0]};
      dec.setflags = ~in_block;
    end else if (is_r16b) begin
      dec.rd = dest_high_idx;
      dec.first_operand_field = dest_high_idx;
      dec.second_operand_field = second_operand_field;
      if (dest_high_idx == ASDEC_REG_SP || second_operand_field == ASDEC_REG_SP) begin
        dec.cls = ASDEC_CLS_SP_PLUS_REG;
      end else begin
        dec.cls = ASDEC_CLS_ADD_REG;
      end
      dec.setflags = 1'b0;
      dec.unpred = (dest_high_idx == ASDEC_REG_PC) &
                   ((in_block & ~last_in_block) | (second_operand_field == ASDEC_REG_PC));
    end else if (is_r32) begin
      dec.rd = wide_dest;
      dec.first_operand_field = wide_first;
      dec.second_operand_field = wide_second;
      case (shift_type_field)
        2'b00: begin
          dec.shift_kind = ASDEC_SH_LSL;
          dec.shift_amt = {1'b0, shift_imm5};
        end
        2'b01: begin
          dec.shift_kind = ASDEC_SH_LSR;
          dec.shift_amt = (shift_imm5 == 5'h00) ? 6'h20 : {1'b0, shift_imm5};
        end
        2'b10: begin
          dec.shift_kind = ASDEC_SH_ASR;
          dec.shift_amt = (shift_imm5 == 5'h00) ? 6'h20 : {1'b0, shift_imm5};
        end
        default: begin
          dec.shift_kind = (shift_imm5 == 5'h00) ? ASDEC_SH_RRX : ASDEC_SH_ROR;
          dec.shift_amt = (shift_imm5 == 5'h00) ? 6'h01 : {1'b0, shift_imm5};
        end
      endcase
      dec.setflags = flag_bit;
      if (wide_dest == ASDEC_REG_PC && flag_bit) begin
        dec.cls = ASDEC_CLS_COMPARE_NEGATIVE_REG;
      end else if (wide_first == ASDEC_REG_SP) begin
        dec.cls = ASDEC_CLS_SP_PLUS_REG;
      end else begin
        dec.cls = ASDEC_CLS_ADD_REG;
        dec.unpred = (wide_dest == ASDEC_REG_SP) | (wide_dest == ASDEC_REG_PC) |
                     (wide_first == ASDEC_REG_PC) | (wide_second == ASDEC_REG_SP) |
                     (wide_second == ASDEC_REG_PC);
      end
    end else if (is_s16a) begin
      dec.cls = ASDEC_CLS_ADD_SP_IMM;
      dec.rd = {1'b0, hw1[10:8]};
      dec.imm32 = {22'h00_0000, byte_immediate, 2'b00};
    end else if (is_s16b) begin
      dec.cls = ASDEC_CLS_ADD_SP_IMM;
      dec.rd = ASDEC_REG_SP;
      dec.imm32 = {23'h00_0000, seven_bit_immediate, 2'b00};
    end else if (is_s32c) begin
      dec.rd = wide_dest;
      dec.setflags = flag_bit;
      dec.imm32 = ex_val;
      if (wide_dest == ASDEC_REG_PC && flag_bit) begin
        dec.cls = ASDEC_CLS_COMPARE_NEGATIVE_IMM;
      end else begin
        dec.cls = ASDEC_CLS_ADD_SP_IMM;
        dec.unpred = (wide_dest == ASDEC_REG_PC) | ex_bad;
      end
    end else if (is_s32w) begin
      dec.cls = ASDEC_CLS_ADD_SP_IMM;
      dec.rd = wide_dest;
      dec.imm32 = {20'h0_0000, imm12};
      dec.unpred = wide_dest == ASDEC_REG_PC;
    end
    // Stack forms read the stack pointer
    dec.first_operand_field = (dec.cls == ASDEC_CLS_ADD_SP_IMM) ? ASDEC_REG_SP : dec.first_operand_field;
  end

  // ==========================================================
  // Shifter
  wire carry_flag = flags_q[ASDEC_FLAG_C];
  wire [4:0] sh5 = dec.shift_amt[4:0];
  wire sh_full = dec.shift_amt == 6'h20;
  // Rotate as a shift of the doubled word
  wire [63:0] rot2 = {opb_q, opb_q} >> sh5;
  wire [31:0] sh_lsl = opb_q << sh5;
  wire [31:0] sh_lsr = sh_full ? 32'h0000_0000 : (opb_q >> sh5);
  wire [31:0] sh_asr = sh_full ? {32{opb_q[31]}} : 32'($signed(opb_q) >>> sh5);
  wire [31:0] sh_rrx = {carry_flag, opb_q[31:1]};
  wire [31:0] shifted = (dec.shift_kind == ASDEC_SH_LSR) ? sh_lsr :
                        (dec.shift_kind == ASDEC_SH_ASR) ? sh_asr :
                        (dec.shift_kind == ASDEC_SH_ROR) ? rot2[31:0] :
                        (dec.shift_kind == ASDEC_SH_RRX) ? sh_rrx : sh_lsl;

  // ==========================================================
  // Adder
  wire sp_form = dec.cls == ASDEC_CLS_ADD_SP_IMM;
  wire reg_form = dec.cls == ASDEC_CLS_ADD_REG;
  wire [31:0] add_a = sp_form ? sp_q : opa_q;
  wire [31:0] add_b = sp_form ? dec.imm32 : shifted;
  wire [32:0] sum33 = {1'b0, add_a} + {1'b0, add_b};
  wire [31:0] sum = sum33[31:0];
  wire add_carry = sum33[32];
  // Like signs in, other sign out
  wire add_ovf = (add_a[31] == add_b[31]) & (sum[31] != add_a[31]);

  // ==========================================================
  // Execute
  // failed condition is a no-operation
  wire exec_ok = go & cond_pass & ~dec.unpred & (reg_form | sp_form);
  wire to_pc = reg_form & (dec.rd == ASDEC_REG_PC);
  always_comb begin
    wb_d = '0;
    flags_d = flags_q;
    // Execution below wins over a flags write
    if (wr_acc & hit_flags) begin
      flags_d = pwdata[3:0];
    end
    if (exec_ok) begin
      wb_d.pc_wr = to_pc;
      wb_d.reg_wr = ~to_pc;
      wb_d.idx = dec.rd;
      wb_d.data = sum;
      if (dec.setflags & ~to_pc) begin
        flags_d[ASDEC_FLAG_N] = sum[31];
        flags_d[ASDEC_FLAG_Z] = sum == 32'h0000_0000;
        flags_d[ASDEC_FLAG_C] = add_carry;
        flags_d[ASDEC_FLAG_V] = add_ovf;
      end
    end
  end

  // ==========================================================
  // Read mux
  wire [31:0] status_word = {16'h0000, 2'b00, done_q, dec.unpred, dec.rd, 3'b000, dec.setflags, 1'b0, dec.cls};
  // Go and unmapped offsets read as zero
  wire [31:0] rd_mux = hit_instr ? instr_q :
                       hit_ctrl ? {29'h0000_0000, ctrl_q} :
                       hit_opa ? opa_q :
                       hit_opb ? opb_q :
                       hit_sp ? sp_q :
                       hit_flags ? {28'h000_0000, flags_q} :
                       hit_status ? status_word :
                       hit_result ? result_q : 32'h0000_0000;

  // ==========================================================
  // Bus answer flops
  // Refusal decided at setup, shown with ready
  wire pslverr_d = setup & (~mapped | ro_write);
  // Read data zero outside a read access
  wire [31:0] prdata_d = (setup & ~pwrite) ? rd_mux : ASDEC_RST_WORD;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= ASDEC_RST_WORD;
    end else begin
      pready_q <= setup;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // ==========================================================
  // Software-written registers
  // Only accepted write accesses reach them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_q <= ASDEC_RST_WORD;
      ctrl_q <= ASDEC_RST_CTRL;
      opa_q <= ASDEC_RST_WORD;
      opb_q <= ASDEC_RST_WORD;
      sp_q <= ASDEC_RST_WORD;
    end else if (wr_acc) begin
      if (hit_instr) instr_q <= pwdata;
      if (hit_ctrl) ctrl_q <= pwdata[2:0];
      if (hit_opa) opa_q <= pwdata;
      if (hit_opb) opb_q <= pwdata;
      if (hit_sp) sp_q <= pwdata;
    end
  end

  // ==========================================================
  // Execution results
  // Result kept even when execution is refused
  wire [31:0] result_d = go ? sum : result_q;
  wire done_d = go ? exec_ok : done_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= ASDEC_RST_FLAGS;
      result_q <= ASDEC_RST_WORD;
      done_q <= 1'b0;
      wb_q <= '0;
    end else begin
      flags_q <= flags_d;
      wb_q <= wb_d;
      result_q <= result_d;
      done_q <= done_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign wb = wb_q;
  assign app_status_flags = flags_q;

endmodule

`default_nettype wire

//--- sim/asdec_checker.sv
// Checker for the add decoder: APB answer timing, refusals, write-back pulses.
// Assumes it is bound to asdec_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module asdec_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Results
  input wire asdec_pkg::asdec_wb_t wb,
  input wire logic [3:0] app_status_flags
);
  import asdec_pkg::*;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========
  // Bus steps
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_ro_write;
    pready && pwrite && (paddr == ASDEC_OFF_STATUS || paddr == ASDEC_OFF_RESULT);
  endsequence

  a_ready_next: assert property (s_setup |=> pready)
    else $error("access cycle without ready");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (pready && paddr > ASDEC_OFF_RESULT |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_ro: assert property (s_ro_write |-> pslverr)
    else $error("read-only write not refused");
  a_no_err: assert property (pready && !pwrite && paddr <= ASDEC_OFF_RESULT |-> !pslverr)
    else $error("mapped read refused");

  // ==========
  // Write-back
  a_wb_cause: assert property (wb.reg_wr || wb.pc_wr |-> $past(pready && pwrite && paddr == ASDEC_OFF_GO))
    else $error("write-back without execute");
  a_wb_single: assert property (wb.reg_wr || wb.pc_wr |=> !wb.reg_wr && !wb.pc_wr)
    else $error("write-back longer than a cycle");
  a_pc_branch: assert property (wb.pc_wr |-> !wb.reg_wr && wb.idx == ASDEC_REG_PC)
    else $error("branch write malformed");
  a_reg_not_pc: assert property (wb.reg_wr |-> wb.idx != ASDEC_REG_PC)
    else $error("register write to pc");
  a_wb_idle: assert property (!(wb.reg_wr || wb.pc_wr) |-> wb.idx == 4'h0 && wb.data == 32'h0)
    else $error("idle write-back not zero");
  a_flags_cause: assert property (!$stable(app_status_flags) |->
    $past(pready && pwrite && (paddr == ASDEC_OFF_FLAGS || paddr == ASDEC_OFF_GO)))
    else $error("flags changed without cause");
  a_flags_need_wr: assert property (!$stable(app_status_flags) && $past(paddr == ASDEC_OFF_GO) |-> wb.reg_wr)
    else $error("flags changed on branch or no-op");
endmodule

bind asdec_top asdec_checker i_asdec_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .wb(wb), .app_status_flags(app_status_flags));

`default_nettype wire

//--- sim/asdec_fetch_model.sv
// Fetch-side stand-in: APB master handing instruction words and operands over.
// Assumes pclk from the bench; waits for pready however long it takes.
`timescale 1ns/1ps
`default_nettype none

module asdec_fetch_model (
  // Clock
  input wire logic pclk,
  // APB master
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [7:0] paddr,
  output var logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
  end

  // One transfer, then an idle cycle
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule

`default_nettype wire

//--- sim/asdec_tb_top.sv
// Self-checking bench for the add decoder: table of encodings, then refusals and reset.
// Assumes asdec_top, its checker and the fetch-side model are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module asdec_tb_top;
  import asdec_pkg::*;

  typedef struct packed {
    logic [31:0] instr;
    logic [31:0] a;
    logic [31:0] b;
    logic [2:0] ctrl;
    logic [3:0] fl_in;
    logic [13:0] st;
    logic full;
    logic [31:0] res;
    logic [3:0] fl_out;
  } asdec_row_t;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  wire logic psel, penable, pwrite, pready, pslverr;
  wire logic [7:0] paddr;
  wire logic [31:0] pwdata, prdata;
  wire asdec_wb_t wb;
  wire logic [3:0] app_status_flags;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] q, keep;
  logic e;
  asdec_wb_t w, exp_wb;
  asdec_row_t rows[20] = '{
    '{32'h188b_0000, 32'h7fff_ffff, 32'h1, 3'h4, 4'h0, 14'h2311, 1'b1, 32'h8000_0000, 4'h9},
    '{32'h188b_0000, 32'hffff_ffff, 32'h1, 3'h5, 4'h6, 14'h2301, 1'b1, 32'h0, 4'h6},
    '{32'h4497_0000, 32'h100, 32'h20, 3'h7, 4'hf, 14'h2f01, 1'b1, 32'h120, 4'hf},
    '{32'h4497_0000, 32'h100, 32'h20, 3'h5, 4'hf, 14'h1f01, 1'b1, 32'h120, 4'hf},
    '{32'h4469_0000, 32'h0, 32'h0, 3'h4, 4'h0, 14'h3, 1'b0, 32'h0, 4'h0},
    '{32'heb12_1413, 32'hff00_0000, 32'h1000_0000, 3'h4, 4'h0, 14'h2411, 1'b1, 32'h0, 4'h6},
    '{32'heb02_0533, 32'h1, 32'h2, 3'h4, 4'h2, 14'h2501, 1'b1, 32'h8000_0002, 4'h2},
    '{32'heb12_0f03, 32'h0, 32'h0, 3'h4, 4'h0, 14'h4, 1'b0, 32'h0, 4'h0},
    '{32'heb1d_0403, 32'h0, 32'h0, 3'h4, 4'h0, 14'h3, 1'b0, 32'h0, 4'h0},
    '{32'heb02_0d03, 32'h1, 32'h2, 3'h4, 4'h0, 14'h1d01, 1'b1, 32'h3, 4'h0},
    '{32'haaff_0000, 32'h1000, 32'h0, 3'h4, 4'h0, 14'h2202, 1'b1, 32'h13fc, 4'h0},
    '{32'hb07f_0000, 32'h100, 32'h0, 3'h4, 4'h0, 14'h2d02, 1'b1, 32'h2fc, 4'h0},
    '{32'hf51d_0600, 32'h7f80_0000, 32'h0, 3'h4, 4'h0, 14'h2612, 1'b1, 32'h8000_0000, 4'h9},
    '{32'hf10d_0f01, 32'h0, 32'h0, 3'h4, 4'h0, 14'h1f02, 1'b1, 32'h1, 4'h0},
    '{32'hf11d_0f00, 32'h0, 32'h0, 3'h4, 4'h0, 14'h5, 1'b0, 32'h0, 4'h0},
    '{32'hf60d_77ff, 32'h1, 32'h0, 3'h4, 4'h0, 14'h2702, 1'b1, 32'h1000, 4'h0},
    '{32'heb12_0123, 32'h1, 32'h8000_0000, 3'h4, 4'h0, 14'h2111, 1'b1, 32'h0, 4'h6},
    '{32'hf10d_3212, 32'h1, 32'h0, 3'h4, 4'h0, 14'h2202, 1'b1, 32'h1212_1213, 4'h0},
    '{32'hf10d_1300, 32'h5, 32'h0, 3'h4, 4'h0, 14'h1302, 1'b1, 32'h5, 4'h0},
    '{32'h188b_0000, 32'h7fff_ffff, 32'h1, 3'h0, 4'h3, 14'h1, 1'b0, 32'h0, 4'h3}
  };

  always #10 pclk = ~pclk;

  asdec_top i_asdec_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wb(wb),
    .app_status_flags(app_status_flags));
  asdec_fetch_model i_asdec_fetch_model (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ==========
  // Helpers
  task check(input string what, input logic [37:0] seen, input logic [37:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    i_asdec_fetch_model.xfer(1'b1, a, d, q, e);
  endtask
  task rd(input logic [7:0] a);
    i_asdec_fetch_model.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task end_of_test;
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      $display("MISMATCH run_length expected under 5000 seen 5000");
      end_of_test();
    end
  end

  // ==========
  // Sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      wr(ASDEC_OFF_INSTR, rows[i].instr);
      wr(ASDEC_OFF_OPA, rows[i].a);
      wr(ASDEC_OFF_OPB, rows[i].b);
      wr(ASDEC_OFF_SP, rows[i].a);
      wr(ASDEC_OFF_CTRL, {29'h0, rows[i].ctrl});
      wr(ASDEC_OFF_FLAGS, {28'h0, rows[i].fl_in});
      wr(ASDEC_OFF_GO, 32'h0);
      w = wb;
      exp_wb = '0;
      if (rows[i].st[13])
        exp_wb = {rows[i].st[11:8] != 4'hf, rows[i].st[11:8] == 4'hf, rows[i].st[11:8], rows[i].res};
      check("wb", w, exp_wb);
      rd(ASDEC_OFF_STATUS);
      check("status", rows[i].full ? q : q & 32'h0000_2007, {18'h0, rows[i].st});
      if (rows[i].full) begin
        rd(ASDEC_OFF_RESULT);
        check("result", q, rows[i].res);
      end
      check("flags", app_status_flags, rows[i].fl_out);
      $display("Row %0d finished", i);
    end
    rd(ASDEC_OFF_RESULT);
    keep = q;
    rd(8'h24);
    check("unmapped_read", {e, q}, {1'b1, 32'h0});
    wr(8'h28, 32'hffff_ffff);
    check("unmapped_write", e, 1'b1);
    wr(ASDEC_OFF_RESULT, ~keep);
    check("result_ro_err", e, 1'b1);
    rd(ASDEC_OFF_RESULT);
    check("result_ro", {e, q}, {1'b0, keep});
    wr(ASDEC_OFF_FLAGS, 32'ha);
    check("flags_write", app_status_flags, 4'ha);
    $display("Refusal tests finished");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("flags_reset", app_status_flags, 4'h0);
    rd(ASDEC_OFF_CTRL);
    check("ctrl_reset", q, 32'h4);
    rd(ASDEC_OFF_INSTR);
    check("instr_reset", q, 32'h0);
    $display("Reset test finished");
    end_of_test();
  end
endmodule

`default_nettype wire
